// file: design/bpk_keeper_cell.sv
// one bank of per-pin keepers with optional reset preset
`timescale 1ns/1ps
module bpk_keeper_cell #(
  parameter int W = 1,
  parameter bit HAS_PRESET = 1'b0,
  parameter logic [W-1:0] PRESET = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // core side
  input wire logic [W-1:0] drvOut,
  input wire logic [W-1:0] drvOe,
  input wire logic [W-1:0] forceHold,
  // pin side
  output logic [W-1:0] keepVal,
  output logic [W-1:0] padOut
);
  logic [W-1:0] keep_q;
  logic [W-1:0] keep_d;

  always_comb begin
    for (int i = 0; i < W; i++) begin
      // take the driven value only while enabled and past preset phase
      keep_d[i] = (drvOe[i] && !forceHold[i]) ? drvOut[i] : keep_q[i];
    end
  end

  // without a preset, the held value starts at zero here; pins treat it as undefined
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      keep_q <= HAS_PRESET ? PRESET : '0;
    end else begin
      keep_q <= keep_d;
    end
  end

  assign keepVal = keep_q;
  // the strong driver while enabled and not force-held, the kept level weakly otherwise
  // per-pin select, so one enabled bit never drags the other pins along
  assign padOut = (drvOe & ~forceHold & drvOut) | (~(drvOe & ~forceHold) & keep_q);
endmodule : bpk_keeper_cell

// file: design/bpk_params.svh
// timing-free constants for the pin keeper block: widths, register bit positions and preset levels
`ifndef BPK_PARAMS_SVH
`define BPK_PARAMS_SVH
`define BPK_ADDR_W 16
`define BPK_DATA_W 16
`define BPK_GRANT_PD_BIT 13
`define BPK_BUS_MASTER_BIT 2
`define BPK_PRESET_SPACE_SEL 1'b1
`define BPK_PRESET_PERIPH_EN 1'b1
`define BPK_PRESET_BUS_STROBE 1'b1
`define BPK_PRESET_READ_STB 1'b1
`define BPK_PRESET_STORE_STB 1'b1
`define BPK_PRESET_DIR_LINE 1'b1
`define BPK_PRESET_TRANSFER_ACK 1'b0
`define BPK_PRESET_BUS_REQUEST 1'b1
`define BPK_PRESET_BUS_GRANT 1'b1
`define BPK_PRESET_BUS_BUSY 1'b1
`define BPK_PRESET_DEBUG_REQ 1'b1
`define BPK_CTRL_PRESET 11'h7ef
`endif

// file: design/bpk_pin_keeper.sv
// pin keepers with reset presets for the expansion port and debug request pin
`timescale 1ns/1ps
`include "bpk_params.svh"
// Overview of operation
// - hardware reset presets control pins high, transfer acknowledge low.
// - preset levels hold until the first external bus access completes.
// - afterwards each kept pin shows its last driven value, even when released.
// - address and data lines have keepers but no reset preset.
// - bus master mode with grant pull-down enable set pulls bus grant low.
// - clearing grant pull-down enable removes the pull-down, keeper takes over.
module bpk_pin_keeper #(
  parameter int ADDR_W = `BPK_ADDR_W,
  parameter int DATA_W = `BPK_DATA_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // mode and bus control register bits from the core
  input wire logic [15:0] operating_mode_reg,
  input wire logic [15:0] bus_control_reg,
  // external access completed strobe
  input wire logic extAccessDone,
  // core drive of control pins
  input wire bpk_pkg::bpk_ctrl_s ctrlOut,
  input wire bpk_pkg::bpk_ctrl_s ctrlOe,
  // core drive of address and data
  input wire logic [ADDR_W-1:0] addrOut,
  input wire logic addrOe,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic dataOe,
  // pin levels
  output bpk_pkg::bpk_ctrl_s ctrlPin,
  output logic [ADDR_W-1:0] addrPin,
  output logic [DATA_W-1:0] dataPin,
  // strong drive enables, low means only the keeper holds the pin; grant pull-down and keeper armed status
  output bpk_pkg::bpk_ctrl_s ctrlStrongOe,
  output logic grantPullLow,
  output logic keeperArmed
);
  import bpk_pkg::*;

  bpk_phase_e phase_q;
  bpk_phase_e phase_d;
  logic [10:0] ctrlHold;
  logic [10:0] ctrlPad;
  logic busMaster;
  logic grantPdEn;

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      BPK_PRESET: begin
        if (extAccessDone) begin
          phase_d = BPK_KEEP;
        end
      end
      BPK_KEEP: begin
        phase_d = BPK_KEEP;
      end
      default: begin
        phase_d = BPK_PRESET;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= BPK_PRESET;
    end else begin
      phase_q <= phase_d;
    end
  end

  // before the first access the core cannot overwrite the presets
  assign ctrlHold = (phase_q == BPK_PRESET) ? 11'h7ff : 11'h000;

  // one keeper per control pin, each tied to its own reset level
  bpk_keeper_cell #(
    .HAS_PRESET(1'b1),
    .PRESET(`BPK_PRESET_SPACE_SEL)
  ) u_keep_space_sel (
    .core_clk(core_clk),
    .nrst(nrst),
    .drvOut(ctrlOut.spaceSel),
    .drvOe(ctrlOe.spaceSel),
    .forceHold(ctrlHold[10]),
    .keepVal(),
    .padOut(ctrlPad[10])
  );

  bpk_keeper_cell #(
    .HAS_PRESET(1'b1),
    .PRESET(`BPK_PRESET_PERIPH_EN)
  ) u_keep_periph_en (
    .core_clk(core_clk),
    .nrst(nrst),
    .drvOut(ctrlOut.periphEn),
    .drvOe(ctrlOe.periphEn),
    .forceHold(ctrlHold[9]),
    .keepVal(),
    .padOut(ctrlPad[9])
  );

  bpk_keeper_cell #(
    .HAS_PRESET(1'b1),
    .PRESET(`BPK_PRESET_BUS_STROBE)
  ) u_keep_bus_strobe (
    .core_clk(core_clk),
    .nrst(nrst),
    .drvOut(ctrlOut.busStrobe),
    .drvOe(ctrlOe.busStrobe),
    .forceHold(ctrlHold[8]),
    .keepVal(),
    .padOut(ctrlPad[8])
  );

  bpk_keeper_cell #(
    .HAS_PRESET(1'b1),
    .PRESET(`BPK_PRESET_READ_STB)
  ) u_keep_read_stb (
    .core_clk(core_clk),
    .nrst(nrst),
    .drvOut(ctrlOut.readStb),
    .drvOe(ctrlOe.readStb),
    .forceHold(ctrlHold[7]),
    .keepVal(),
    .padOut(ctrlPad[7])
  );

  bpk_keeper_cell #(
    .HAS_PRESET(1'b1),
    .PRESET(`BPK_PRESET_STORE_STB)
  ) u_keep_store_stb (
    .core_clk(core_clk),
    .nrst(nrst),
    .drvOut(ctrlOut.storeStb),
    .drvOe(ctrlOe.storeStb),
    .forceHold(ctrlHold[6]),
    .keepVal(),
    .padOut(ctrlPad[6])
  );

  bpk_keeper_cell #(
    .HAS_PRESET(1'b1),
    .PRESET(`BPK_PRESET_DIR_LINE)
  ) u_keep_dir_line (
    .core_clk(core_clk),
    .nrst(nrst),
    .drvOut(ctrlOut.dirLine),
    .drvOe(ctrlOe.dirLine),
    .forceHold(ctrlHold[5]),
    .keepVal(),
    .padOut(ctrlPad[5])
  );

  bpk_keeper_cell #(
    .HAS_PRESET(1'b1),
    .PRESET(`BPK_PRESET_TRANSFER_ACK)
  ) u_keep_transfer_ack (
    .core_clk(core_clk),
    .nrst(nrst),
    .drvOut(ctrlOut.transferAck),
    .drvOe(ctrlOe.transferAck),
    .forceHold(ctrlHold[4]),
    .keepVal(),
    .padOut(ctrlPad[4])
  );

  bpk_keeper_cell #(
    .HAS_PRESET(1'b1),
    .PRESET(`BPK_PRESET_BUS_REQUEST)
  ) u_keep_bus_request (
    .core_clk(core_clk),
    .nrst(nrst),
    .drvOut(ctrlOut.busRequest),
    .drvOe(ctrlOe.busRequest),
    .forceHold(ctrlHold[3]),
    .keepVal(),
    .padOut(ctrlPad[3])
  );

  bpk_keeper_cell #(
    .HAS_PRESET(1'b1),
    .PRESET(`BPK_PRESET_BUS_GRANT)
  ) u_keep_bus_grant (
    .core_clk(core_clk),
    .nrst(nrst),
    .drvOut(ctrlOut.busGrant),
    .drvOe(ctrlOe.busGrant),
    .forceHold(ctrlHold[2]),
    .keepVal(),
    .padOut(ctrlPad[2])
  );

  bpk_keeper_cell #(
    .HAS_PRESET(1'b1),
    .PRESET(`BPK_PRESET_BUS_BUSY)
  ) u_keep_bus_busy (
    .core_clk(core_clk),
    .nrst(nrst),
    .drvOut(ctrlOut.busBusyLine),
    .drvOe(ctrlOe.busBusyLine),
    .forceHold(ctrlHold[1]),
    .keepVal(),
    .padOut(ctrlPad[1])
  );

  bpk_keeper_cell #(
    .HAS_PRESET(1'b1),
    .PRESET(`BPK_PRESET_DEBUG_REQ)
  ) u_keep_debug_req (
    .core_clk(core_clk),
    .nrst(nrst),
    .drvOut(ctrlOut.debugRequest),
    .drvOe(ctrlOe.debugRequest),
    .forceHold(ctrlHold[0]),
    .keepVal(),
    .padOut(ctrlPad[0])
  );

  bpk_keeper_cell #(
    .W(ADDR_W)
  ) u_addr_keep (
    .core_clk(core_clk),
    .nrst(nrst),
    .drvOut(addrOut),
    .drvOe({ADDR_W{addrOe}}),
    .forceHold({ADDR_W{1'b0}}),
    .keepVal(),
    .padOut(addrPin)
  );

  bpk_keeper_cell #(
    .W(DATA_W)
  ) u_data_keep (
    .core_clk(core_clk),
    .nrst(nrst),
    .drvOut(dataOut),
    .drvOe({DATA_W{dataOe}}),
    .forceHold({DATA_W{1'b0}}),
    .keepVal(),
    .padOut(dataPin)
  );

  assign busMaster = operating_mode_reg[`BPK_BUS_MASTER_BIT];
  assign grantPdEn = bus_control_reg[`BPK_GRANT_PD_BIT];
  // pull-down only while both bits set; cleared bit returns pin to keeper
  assign grantPullLow = busMaster && grantPdEn;

  always_comb begin
    ctrlPin = ctrlPad;
    ctrlStrongOe = ctrlOe & ~ctrlHold;
    if (grantPullLow) begin
      ctrlPin.busGrant = 1'b0;
    end
  end

  assign keeperArmed = (phase_q == BPK_KEEP);
endmodule : bpk_pin_keeper

// file: design/bpk_pkg.sv
// types shared by the pin keeper block
package bpk_pkg;
  typedef struct packed {
    logic spaceSel;
    logic periphEn;
    logic busStrobe;
    logic readStb;
    logic storeStb;
    logic dirLine;
    logic transferAck;
    logic busRequest;
    logic busGrant;
    logic busBusyLine;
    logic debugRequest;
  } bpk_ctrl_s;
  typedef enum logic [0:0] {
    BPK_PRESET = 1'b0,
    BPK_KEEP = 1'b1
  } bpk_phase_e;
endpackage : bpk_pkg

// file: dv/bpk_far_mem.sv
// far-side memory model, one word taken on the store strobe
`timescale 1ns/1ps
module bpk_far_mem (
  // pins seen
  input wire logic core_clk,
  input wire bpk_pkg::bpk_ctrl_s ctrlPin,
  input wire logic [15:0] dataPin,
  // stored word
  output logic [15:0] word
);
  always_ff @(posedge core_clk) begin
    if (!ctrlPin.storeStb) word <= dataPin;
  end
endmodule : bpk_far_mem

// file: dv/bpk_pin_keeper_props.sv
// checker for the pin keeper block
`timescale 1ns/1ps
module bpk_pin_keeper_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // core side
  input wire logic [15:0] operating_mode_reg,
  input wire logic [15:0] bus_control_reg,
  input wire logic extAccessDone,
  input wire bpk_pkg::bpk_ctrl_s ctrlOut,
  input wire bpk_pkg::bpk_ctrl_s ctrlOe,
  input wire logic [15:0] addrOut,
  input wire logic addrOe,
  // pin side
  input wire bpk_pkg::bpk_ctrl_s ctrlPin,
  input wire bpk_pkg::bpk_ctrl_s ctrlStrongOe,
  input wire logic [15:0] addrPin,
  input wire logic grantPullLow,
  input wire logic keeperArmed
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_preset_levels: assert property (!keeperArmed && !grantPullLow |-> ctrlPin == 11'h7ef)
    else $error("preset lost");
  a_no_drive_unarmed: assert property (!keeperArmed |-> ctrlStrongOe == '0)
    else $error("early drive");
  a_arm_next: assert property (extAccessDone |=> keeperArmed)
    else $error("not armed");
  a_arm_sticky: assert property (keeperArmed |=> keeperArmed)
    else $error("arm lost");
  a_strong_armed: assert property (keeperArmed |-> ctrlStrongOe == ctrlOe)
    else $error("drive blocked");
  a_ctrl_keep: assert property ($past(keeperArmed) && $past(ctrlOe.readStb) && !ctrlOe.readStb
    |-> ctrlPin.readStb == $past(ctrlOut.readStb)) else $error("ctrl not kept");
  a_addr_keep: assert property ($past(nrst) && $past(addrOe) && !addrOe |-> addrPin == $past(addrOut))
    else $error("addr not kept");
  a_pull_cause: assert property (grantPullLow == (operating_mode_reg[2] && bus_control_reg[13]))
    else $error("pull-down wrong");
  a_pull_grant: assert property (grantPullLow |-> !ctrlPin.busGrant)
    else $error("grant not low");
endmodule : bpk_pin_keeper_props
bind bpk_pin_keeper bpk_pin_keeper_props u_props (.*);

// file: dv/bpk_pin_keeper_test.sv
// self-checking bench for the pin keeper
`timescale 1ns/1ps
module bpk_pin_keeper_test;
  import bpk_pkg::*;
  logic core_clk = 0, nrst = 0, extAccessDone = 0, addrOe = 0, dataOe = 0, grantPullLow, keeperArmed;
  logic [15:0] operating_mode_reg = '0, bus_control_reg = '0, addrOut = '0, dataOut = '0, addrPin, dataPin, word;
  bpk_ctrl_s ctrlOut = '0, ctrlOe = '0, ctrlPin, ctrlStrongOe;
  int fails = 0, cmp_count = 0, cyc = 0;
  // mode bit, enable bit, pull expected, grant pin expected
  logic [3:0] pd [5] = '{4'h1, 4'h5, 4'h9, 4'he, 4'h9};
  always #12.5 core_clk = ~core_clk;
  bpk_pin_keeper dut (.*);
  bpk_far_mem mem (.core_clk, .ctrlPin, .dataPin, .word);
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("%0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  always @(posedge core_clk) if (++cyc > 300) begin
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1;
    @(posedge core_clk);
    ctrlOe <= '1;
    #1;
    chk(ctrlPin, 11'h7ef);
    chk(ctrlStrongOe, 11'h000);
    @(posedge core_clk);
    extAccessDone <= 1;
    @(posedge core_clk);
    extAccessDone <= 0;
    #1;
    chk(keeperArmed, 1);
    chk(ctrlStrongOe, 11'h7ff);
    $display("preset test done");
    // last value leaves the grant pin kept high
    foreach (pd[i]) begin
      @(posedge core_clk);
      ctrlOe <= '1;
      ctrlOut <= {i[0], 10'h155};
      @(posedge core_clk);
      ctrlOe <= '0;
      ctrlOut <= '0;
      #1;
      chk(ctrlPin, {i[0], 10'h155});
    end
    @(posedge core_clk);
    {addrOe, dataOe, ctrlOe.storeStb} <= '1;
    {addrOut, dataOut} <= 32'h5a3cc3a5;
    @(posedge core_clk);
    {addrOe, dataOe, ctrlOut.storeStb} <= 3'h1;
    {addrOut, dataOut} <= '0;
    #1;
    chk(addrPin, 16'h5a3c);
    chk(word, 16'hc3a5);
    chk(dataPin, 16'hc3a5);
    $display("keeper test done");
    foreach (pd[i]) begin
      @(posedge core_clk);
      operating_mode_reg[2] <= pd[i][3];
      bus_control_reg[13] <= pd[i][2];
      #1;
      chk(grantPullLow, pd[i][1]);
      chk(ctrlPin.busGrant, pd[i][0]);
    end
    $display("pull-down test done");
    @(posedge core_clk);
    nrst <= 0;
    #1;
    chk(ctrlPin, 11'h7ef);
    chk(keeperArmed, 1'b0);
    @(posedge core_clk);
    nrst <= 1;
    ctrlOut <= '0;
    ctrlOe <= '1;
    @(posedge core_clk);
    #1;
    chk(ctrlPin, 11'h7ef);
    chk(ctrlStrongOe, 11'h000);
    $display("reset test done");
    report_and_stop();
  end
endmodule : bpk_pin_keeper_test
